//--- rcv_pkg.sv
// Shared constants and carrier types for the dual-channel rod interlock voter
package rcv_pkg;
  localparam int POS_W = 16;
  localparam int REED_N = 8;
  localparam int STAMP_W = 24;
  localparam int MANUAL_PB_N = 2;
  localparam int REC_DEPTH_DEF = 64;
  localparam int DISAGREE_CYC_DEF = 16;
  localparam int POS_TOL_DEF = 4;

  // Outputs of one redundant logic channel
  typedef struct packed {
    logic rod_block;
    logic withdraw;
    logic insert;
    logic emerg_vote;
  } rcv_chan_t;

  // Control inputs of one operator panel
  typedef struct packed {
    logic reset;
    logic withdraw;
    logic insert;
  } rcv_panel_t;

  // Movement command towards the inverter controller
  typedef struct packed {
    logic withdraw;
    logic insert;
    logic emerg;
  } rcv_move_t;

  // Status from inverter controller and motor driver module
  typedef struct packed {
    logic inv_ok;
    logic drv_ok;
  } rcv_drive_stat_t;

  // One scram timing record
  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [REED_N-1:0] reeds;
  } rcv_rec_t;

  // Every pin input, synchronised as one group
  typedef struct packed {
    rcv_chan_t chan_a;
    rcv_chan_t chan_b;
    logic chan_a_fail;
    logic chan_b_fail;
    logic scram_follow;
    logic alternate_insertion;
    logic selected_run_in;
    logic [MANUAL_PB_N-1:0] manual_run_in;
    logic insert_panel;
    logic panel_backup_sel;
    rcv_panel_t main_panel;
    rcv_panel_t backup_panel;
    logic [POS_W-1:0] pos_a;
    logic [POS_W-1:0] pos_b;
    rcv_drive_stat_t drive_stat;
    logic brake_stat_a;
    logic brake_stat_b;
    logic [REED_N-1:0] reeds;
    logic scram_test;
    logic full_scram;
    logic rec_rd;
  } rcv_pins_t;

  typedef enum {REC_IDLE, REC_RUN} rcv_rec_state_t;
endpackage

//--- rcv_recorder.sv
// Scram time recorder: time-stamps reed switch changes and hands records out in order
`timescale 1ns/1ps
module rcv_recorder #(
  parameter int DEPTH = rcv_pkg::REC_DEPTH_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [rcv_pkg::REED_N-1:0] reeds_in,
  input wire logic start_in,
  input wire logic clear_in,
  input wire logic rd_in,
  output logic rec_valid_out,
  output rcv_pkg::rcv_rec_t rec_data_out,
  output logic recording_out
);
  import rcv_pkg::*;

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("Recorder depth must be a power of two, at least 2");
    end
  end

  rcv_rec_t mem [DEPTH];
  rcv_rec_state_t state_reg;
  logic [STAMP_W-1:0] stamp_reg;
  logic [REED_N-1:0] last_reg;
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] wr_ptr_next;
  logic [AW:0] rd_ptr_next;
  logic full;
  logic wr_en;
  logic rd_en;
  rcv_rec_t new_rec;

  assign full = (wr_ptr_reg - rd_ptr_reg) == (AW + 1)'(DEPTH);
  // Once full, later changes are dropped so the start of the scram is kept
  assign wr_en = (state_reg == REC_RUN) && (reeds_in != last_reg) && !full && !clear_in;
  assign rd_en = rd_in && rec_valid_out && !clear_in;
  assign new_rec = '{stamp: stamp_reg, reeds: reeds_in};
  assign wr_ptr_next = clear_in ? '0 : (wr_ptr_reg + (AW + 1)'(wr_en));
  assign rd_ptr_next = clear_in ? '0 : (rd_ptr_reg + (AW + 1)'(rd_en));

  // Free-running time base on the system clock
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stamp_reg <= '0;
    end else begin
      stamp_reg <= stamp_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= REC_IDLE;
    end else begin
      case (state_reg)
        REC_IDLE: begin
          if (start_in && !clear_in) begin
            state_reg <= REC_RUN;
          end
        end
        REC_RUN: begin
          if (clear_in) begin
            state_reg <= REC_IDLE;
          end
        end
        default: state_reg <= REC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_reg <= '0;
    end else begin
      last_reg <= reeds_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (wr_en) begin
      mem[wr_ptr_reg[AW-1:0]] <= new_rec;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Head record is registered; a write into the slot being read is bypassed
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rec_valid_out <= 1'b0;
      rec_data_out <= '0;
      recording_out <= 1'b0;
    end else begin
      rec_valid_out <= wr_ptr_next != rd_ptr_next;
      if (wr_en && wr_ptr_reg[AW-1:0] == rd_ptr_next[AW-1:0]) begin
        rec_data_out <= new_rec;
      end else begin
        rec_data_out <= mem[rd_ptr_next[AW-1:0]];
      end
      recording_out <= (state_reg == REC_RUN) && !clear_in;
    end
  end

  rec_start_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_reg == REC_IDLE && start_in && !clear_in) ##1 !clear_in |=> recording_out)
    else $error("Recorder did not start after trigger");
endmodule

//--- rcv_voter.sv
// Dual-channel rod interlock voter with emergency insertion vote and scram recording
//
// Contract
// - Compare both channels continuously; sustained disagreement raises rod block.
// - Either channel alone can raise the rod block.
// - Emergency insertion needs channel A, channel B and insertion panel together.
// - A single failed channel is bypassed, only while emergency insertion is active.
// - Emergency insertion is active if scram-follow, alternate or selected run-in is.
// - Insertion panel output driven by trip, flow controller or two manual buttons.
// - Selector grants control to main or backup panel only; other ignored.
// - All-rod run-in command drives hardwired pump runback output.
// - Both position words are used by control and monitoring logic.
// - Inverter takes agreed movement commands; its status returns to channels.
// - Brake commanded from here; one brake status line returns per channel.
// - Reed changes time-stamped after scram test or full-core scram starts.
// - Recorded timing records can be transferred to the analysis panel.
// - Latched trips hold until operator reset from selected panel.
`timescale 1ns/1ps
module rcv_voter #(
  parameter int DISAGREE_CYCLES = rcv_pkg::DISAGREE_CYC_DEF,
  parameter int POS_TOLERANCE = rcv_pkg::POS_TOL_DEF,
  parameter int REC_DEPTH = rcv_pkg::REC_DEPTH_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire rcv_pkg::rcv_chan_t chan_a_in,
  input wire rcv_pkg::rcv_chan_t chan_b_in,
  input wire logic chan_a_fail_in,
  input wire logic chan_b_fail_in,
  input wire logic scram_follow_in,
  input wire logic alternate_insertion_in,
  input wire logic selected_run_in_in,
  input wire logic [rcv_pkg::MANUAL_PB_N-1:0] manual_run_in_in,
  input wire logic insert_panel_in,
  input wire logic panel_backup_sel_in,
  input wire rcv_pkg::rcv_panel_t main_panel_in,
  input wire rcv_pkg::rcv_panel_t backup_panel_in,
  input wire logic [rcv_pkg::POS_W-1:0] pos_a_in,
  input wire logic [rcv_pkg::POS_W-1:0] pos_b_in,
  input wire rcv_pkg::rcv_drive_stat_t drive_stat_in,
  input wire logic brake_stat_a_in,
  input wire logic brake_stat_b_in,
  input wire logic [rcv_pkg::REED_N-1:0] reeds_in,
  input wire logic scram_test_in,
  input wire logic full_scram_in,
  input wire logic rec_rd_in,
  output logic rod_block_out,
  output rcv_pkg::rcv_move_t move_out,
  output logic emerg_panel_out,
  output logic runback_out,
  output logic brake_release_out,
  output rcv_pkg::rcv_drive_stat_t drive_stat_a_out,
  output rcv_pkg::rcv_drive_stat_t drive_stat_b_out,
  output logic brake_fb_a_out,
  output logic brake_fb_b_out,
  output logic [rcv_pkg::POS_W-1:0] pos_word_out,
  output logic rec_valid_out,
  output rcv_pkg::rcv_rec_t rec_data_out,
  output logic recording_out
);
  import rcv_pkg::*;

  localparam int DIS_W = $clog2(DISAGREE_CYCLES + 1);

  initial begin
    if (DISAGREE_CYCLES < 1) begin
      $error("DISAGREE_CYCLES must be at least 1");
    end
    if (POS_TOLERANCE < 0 || POS_TOLERANCE >= (1 << POS_W)) begin
      $error("POS_TOLERANCE out of range");
    end
  end

  rcv_pins_t pins_raw;
  rcv_pins_t sync1_reg;
  rcv_pins_t sync2_reg;
  logic rd_prev_reg;
  logic [DIS_W-1:0] dis_cnt_reg;
  logic block_latch_reg;

  rcv_pins_t s;
  rcv_panel_t sel_panel;
  logic op_reset;
  logic mismatch;
  logic dis_hit;
  logic [POS_W-1:0] pos_diff;
  logic pos_bad;
  logic block_cause;
  logic emerg_active;
  logic bypass_a;
  logic bypass_b;
  logic vote_a;
  logic vote_b;
  logic emerg_go;
  rcv_move_t move_next;
  logic rec_start;
  logic rec_pop;

  assign pins_raw = '{
    chan_a: chan_a_in,
    chan_b: chan_b_in,
    chan_a_fail: chan_a_fail_in,
    chan_b_fail: chan_b_fail_in,
    scram_follow: scram_follow_in,
    alternate_insertion: alternate_insertion_in,
    selected_run_in: selected_run_in_in,
    manual_run_in: manual_run_in_in,
    insert_panel: insert_panel_in,
    panel_backup_sel: panel_backup_sel_in,
    main_panel: main_panel_in,
    backup_panel: backup_panel_in,
    pos_a: pos_a_in,
    pos_b: pos_b_in,
    drive_stat: drive_stat_in,
    brake_stat_a: brake_stat_a_in,
    brake_stat_b: brake_stat_b_in,
    reeds: reeds_in,
    scram_test: scram_test_in,
    full_scram: full_scram_in,
    rec_rd: rec_rd_in
  };

  // Every pin input crosses two flops before any logic sees it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      rd_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      rd_prev_reg <= sync2_reg.rec_rd;
    end
  end

  assign s = sync2_reg;

  // Only the granted panel's controls reach the logic
  assign sel_panel = s.panel_backup_sel ? s.backup_panel : s.main_panel;
  assign op_reset = sel_panel.reset;

  // Channel rod-block flags are voted separately, so they are left out here
  assign mismatch = (s.chan_a.withdraw != s.chan_b.withdraw) ||
                    (s.chan_a.insert != s.chan_b.insert) ||
                    (s.chan_a.emerg_vote != s.chan_b.emerg_vote);
  assign dis_hit = mismatch && (dis_cnt_reg == DIS_W'(DISAGREE_CYCLES - 1));

  // Both converter words are checked against each other
  assign pos_diff = (s.pos_a > s.pos_b) ? (s.pos_a - s.pos_b) : (s.pos_b - s.pos_a);
  assign pos_bad = pos_diff > POS_W'(POS_TOLERANCE);

  assign block_cause = dis_hit || s.chan_a.rod_block || s.chan_b.rod_block || pos_bad;

  assign emerg_active = s.scram_follow || s.alternate_insertion || s.selected_run_in;
  // Bypass only one failed channel; with both failed the vote stays closed
  assign bypass_a = emerg_active && s.chan_a_fail && !s.chan_b_fail;
  assign bypass_b = emerg_active && s.chan_b_fail && !s.chan_a_fail;
  assign vote_a = s.chan_a.emerg_vote || bypass_a;
  assign vote_b = s.chan_b.emerg_vote || bypass_b;
  assign emerg_go = vote_a && vote_b && s.insert_panel;

  always_comb begin
    move_next = '0;
    move_next.emerg = emerg_go;
    // Normal motion needs both channels in agreement and no rod block
    if (!emerg_go && !block_latch_reg && !block_cause) begin
      move_next.withdraw = s.chan_a.withdraw && s.chan_b.withdraw && sel_panel.withdraw;
      move_next.insert = s.chan_a.insert && s.chan_b.insert && sel_panel.insert;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dis_cnt_reg <= '0;
    end else if (!mismatch) begin
      dis_cnt_reg <= '0;
    end else if (dis_cnt_reg != DIS_W'(DISAGREE_CYCLES)) begin
      dis_cnt_reg <= dis_cnt_reg + 1'b1;
    end
  end

  // A new cause wins over an operator reset in the same cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      block_latch_reg <= 1'b0;
    end else begin
      block_latch_reg <= block_cause || (block_latch_reg && !op_reset);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rod_block_out <= 1'b0;
    end else begin
      rod_block_out <= block_cause || (block_latch_reg && !op_reset);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      move_out <= '0;
      brake_release_out <= 1'b0;
    end else begin
      move_out <= move_next;
      brake_release_out <= move_next.withdraw || move_next.insert || move_next.emerg;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      emerg_panel_out <= 1'b0;
      runback_out <= 1'b0;
    end else begin
      emerg_panel_out <= emerg_active || (|s.manual_run_in);
      runback_out <= s.scram_follow || s.alternate_insertion;
    end
  end

  // Status returns to each channel, brake status kept per channel
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_stat_a_out <= '0;
      drive_stat_b_out <= '0;
      brake_fb_a_out <= 1'b0;
      brake_fb_b_out <= 1'b0;
      pos_word_out <= '0;
    end else begin
      drive_stat_a_out <= s.drive_stat;
      drive_stat_b_out <= s.drive_stat;
      brake_fb_a_out <= s.brake_stat_a;
      brake_fb_b_out <= s.brake_stat_b;
      if (!pos_bad) begin
        pos_word_out <= s.pos_a;
      end
    end
  end

  assign rec_start = s.scram_test || s.full_scram;
  assign rec_pop = s.rec_rd && !rd_prev_reg;

  rcv_recorder #(
    .DEPTH(REC_DEPTH)
  ) u_recorder (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .reeds_in(s.reeds),
    .start_in(rec_start),
    .clear_in(op_reset),
    .rd_in(rec_pop),
    .rec_valid_out(rec_valid_out),
    .rec_data_out(rec_data_out),
    .recording_out(recording_out)
  );

  sustained_block_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    dis_hit |=> rod_block_out)
    else $error("Sustained disagreement did not block");

  short_mismatch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!block_latch_reg && !block_cause) |=> !rod_block_out)
    else $error("Rod block without a cause");

  single_chan_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (s.chan_a.rod_block || s.chan_b.rod_block) |=> rod_block_out && !move_out.withdraw)
    else $error("Single channel block ignored");

  emerg_vote_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    move_out.emerg |-> $past(s.insert_panel) && $past(vote_a) && $past(vote_b))
    else $error("Emergency motion without full vote");

  bypass_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!emerg_active && !s.chan_a.emerg_vote) |=> !move_out.emerg)
    else $error("Bypass engaged outside emergency insertion");

  agree_move_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    move_out.withdraw |-> $past(s.chan_a.withdraw) && $past(s.chan_b.withdraw))
    else $error("Withdraw without channel agreement");

  panel_ignore_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (rod_block_out && s.panel_backup_sel && !s.backup_panel.reset) |=> rod_block_out)
    else $error("Unselected panel cleared the block");

  latch_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (block_latch_reg && !op_reset) |=> rod_block_out && block_latch_reg)
    else $error("Latched trip dropped without reset");

  runback_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (s.scram_follow || s.alternate_insertion) |=> runback_out)
    else $error("Runback not driven for all-rod run-in");

  manual_run_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (|s.manual_run_in) |=> emerg_panel_out)
    else $error("Manual run-in did not reach panel output");
endmodule

//--- rcv_partner.sv
// Far-side model: redundant channel outputs, inverter status and brake controller
`timescale 1ns/1ps
module rcv_partner (
  input wire logic sys_clk_in,
  input wire rcv_pkg::rcv_chan_t want_in,
  input wire rcv_pkg::rcv_chan_t skew_b_in,
  input wire logic brake_release_in,
  input wire logic inv_fault_in,
  input wire logic drv_fault_in,
  input wire logic brake_split_in,
  output rcv_pkg::rcv_chan_t chan_a_out,
  output rcv_pkg::rcv_chan_t chan_b_out,
  output rcv_pkg::rcv_drive_stat_t drive_stat_out,
  output logic brake_stat_a_out,
  output logic brake_stat_b_out
);
  import rcv_pkg::*;
  logic released_reg;
  // Channel B differs from A only where a scenario injects a fault
  assign chan_a_out = want_in;
  assign chan_b_out = want_in ^ skew_b_in;
  assign drive_stat_out = '{inv_ok: !inv_fault_in, drv_ok: !drv_fault_in};
  // The brake follows its command one cycle late, as a real actuator lags
  always_ff @(posedge sys_clk_in) begin
    released_reg <= brake_release_in;
  end
  assign brake_stat_a_out = released_reg;
  assign brake_stat_b_out = released_reg ^ brake_split_in;
endmodule

//--- tb_rcv_voter.sv
// Self-checking bench for the dual-channel rod interlock voter
`timescale 1ns/1ps
module tb_rcv_voter;
  import rcv_pkg::*;
  localparam int DC = 2;
  localparam int DEPTH = 4;
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  rcv_chan_t want = '0;
  rcv_chan_t skew = '0;
  rcv_chan_t ch_a;
  rcv_chan_t ch_b;
  logic a_fail = 1'h0;
  logic b_fail = 1'h0;
  logic [4:0] req = '0;
  logic ipanel = 1'h0;
  logic psel = 1'h0;
  rcv_panel_t mpan = '0;
  rcv_panel_t bpan = '0;
  logic [15:0] pos_a = 16'h0100;
  logic [15:0] pos_b = 16'h0100;
  rcv_drive_stat_t dstat;
  logic inv_f = 1'h0;
  logic drv_f = 1'h0;
  logic split = 1'h0;
  logic bsa;
  logic bsb;
  logic [7:0] reeds = '0;
  logic stest = 1'h0;
  logic fscram = 1'h0;
  logic rd = 1'h0;
  logic rod_block;
  rcv_move_t move;
  logic epanel;
  logic runback;
  logic brel;
  rcv_drive_stat_t dsa;
  rcv_drive_stat_t dsb;
  logic fba;
  logic fbb;
  logic [15:0] posw;
  logic rvalid;
  rcv_rec_t rdata;
  logic recording;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] rq[$];
  int tq[$];
  logic [5:0] v;
  logic [23:0] s0;

  always #10 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc <= cyc + 1;

  rcv_partner far (.sys_clk_in(sys_clk_in), .want_in(want), .skew_b_in(skew),
    .brake_release_in(brel), .inv_fault_in(inv_f), .drv_fault_in(drv_f),
    .brake_split_in(split), .chan_a_out(ch_a), .chan_b_out(ch_b),
    .drive_stat_out(dstat), .brake_stat_a_out(bsa), .brake_stat_b_out(bsb));

  rcv_voter #(.DISAGREE_CYCLES(DC), .REC_DEPTH(DEPTH)) uut (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .chan_a_in(ch_a), .chan_b_in(ch_b), .chan_a_fail_in(a_fail),
    .chan_b_fail_in(b_fail), .scram_follow_in(req[4]), .alternate_insertion_in(req[3]),
    .selected_run_in_in(req[2]), .manual_run_in_in(req[1:0]), .insert_panel_in(ipanel),
    .panel_backup_sel_in(psel), .main_panel_in(mpan), .backup_panel_in(bpan),
    .pos_a_in(pos_a), .pos_b_in(pos_b), .drive_stat_in(dstat), .brake_stat_a_in(bsa),
    .brake_stat_b_in(bsb), .reeds_in(reeds), .scram_test_in(stest),
    .full_scram_in(fscram), .rec_rd_in(rd), .rod_block_out(rod_block), .move_out(move),
    .emerg_panel_out(epanel), .runback_out(runback), .brake_release_out(brel),
    .drive_stat_a_out(dsa), .drive_stat_b_out(dsb), .brake_fb_a_out(fba),
    .brake_fb_b_out(fbb), .pos_word_out(posw), .rec_valid_out(rvalid),
    .rec_data_out(rdata), .recording_out(recording));

  function automatic logic exp_go(input logic [5:0] x);
    // Vote A, vote B, panel, fail A, fail B, insertion active
    return (x[5] | (x[0] & x[2] & !x[1])) & (x[4] | (x[0] & x[1] & !x[2])) & x[3];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs cross two sync stages and an output flop before they show
  task automatic settle();
    repeat (4) @(negedge sys_clk_in);
  endtask

  task automatic op_reset(input logic backup);
    if (backup) bpan.reset = 1'h1;
    else mpan.reset = 1'h1;
    settle();
    mpan.reset = 1'h0;
    bpan.reset = 1'h0;
    settle();
  endtask

  task automatic wrap_up();
    $display("mismatches %0d of %0d comparisons", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(58225));
    repeat (8) @(negedge sys_clk_in);
    rst_in = 1'h0;
    @(negedge sys_clk_in);
    chk(32'({rod_block, move, epanel, runback, brel, rvalid, recording}), 32'h0);
    for (int i = 0; i < 24; i++) begin
      req = 5'($urandom);
      {inv_f, drv_f, split} = 3'($urandom);
      settle();
      chk(32'(epanel), 32'(|req));
      chk(32'(runback), 32'(req[4] | req[3]));
      chk(32'({dsa, dsb}), 32'({!inv_f, !drv_f, !inv_f, !drv_f}));
      chk(32'({fba, fbb}), 32'({bsa, bsb}));
    end
    {req, inv_f, drv_f, split} = '0;
    pos_a = 16'(16 + $urandom % 60000);
    pos_b = pos_a;
    want.withdraw = 1'h1;
    mpan.withdraw = 1'h1;
    settle();
    chk(32'(move), 32'h4);
    chk(32'(brel), 32'h1);
    skew.withdraw = 1'h1;
    @(negedge sys_clk_in);
    skew.withdraw = 1'h0;
    settle();
    chk(32'(rod_block), 32'h0);
    skew.withdraw = 1'h1;
    repeat (DC) @(negedge sys_clk_in);
    skew.withdraw = 1'h0;
    settle();
    chk(32'(rod_block), 32'h1);
    chk(32'(move), 32'h0);
    chk(32'(brel), 32'h0);
    op_reset(1'h1);
    chk(32'(rod_block), 32'h1);
    op_reset(1'h0);
    chk(32'(rod_block), 32'h0);
    chk(32'(move), 32'h4);
    {want.withdraw, want.insert, mpan.withdraw, mpan.insert} = 4'h5;
    settle();
    chk(32'(move), 32'h2);
    chk(32'(brel), 32'h1);
    // Backup panel holds no insert request, so the granted panel blocks motion
    psel = 1'h1;
    settle();
    chk(32'(move), 32'h0);
    want.rod_block = 1'h1;
    skew.rod_block = 1'h1;
    settle();
    chk(32'(rod_block), 32'h1);
    want.rod_block = 1'h0;
    skew.rod_block = 1'h0;
    op_reset(1'h0);
    chk(32'(rod_block), 32'h1);
    op_reset(1'h1);
    chk(32'(rod_block), 32'h0);
    psel = 1'h0;
    pos_b = pos_a + 16'h0004;
    settle();
    chk(32'(rod_block), 32'h0);
    chk(32'(posw), 32'(pos_a));
    pos_b = pos_a - 16'h0005;
    settle();
    chk(32'(rod_block), 32'h1);
    pos_b = pos_a;
    {want.insert, mpan.insert} = 2'h0;
    // Bypass corners first, then random vote patterns
    for (int i = 0; i < 43; i++) begin
      v = (i == 0) ? 6'h1d : (i == 1) ? 6'h1c : (i == 2) ? 6'h1f : 6'($urandom);
      want.emerg_vote = v[5];
      skew.emerg_vote = v[5] ^ v[4];
      ipanel = v[3];
      a_fail = v[2];
      b_fail = v[1];
      req = v[0] ? (5'h10 >> ($urandom % 3)) : 5'h0;
      settle();
      chk(32'(move.emerg), 32'(exp_go(v)));
    end
    {want, skew, ipanel, a_fail, b_fail, req} = '0;
    op_reset(1'h0);
    reeds = 8'h5a;
    settle();
    chk(32'(rvalid), 32'h0);
    fscram = 1'h1;
    settle();
    chk(32'(recording), 32'h1);
    // Two changes beyond capacity check that the earliest records are kept
    for (int k = 0; k < DEPTH + 2; k++) begin
      reeds = reeds ^ 8'(1 + $urandom % 255);
      if (k < DEPTH) begin
        rq.push_back(reeds);
        tq.push_back(cyc);
      end
      repeat (3 + k) @(negedge sys_clk_in);
    end
    settle();
    s0 = rdata.stamp;
    for (int k = 0; k < DEPTH; k++) begin
      chk(32'(rvalid), 32'h1);
      chk(32'(rdata.reeds), 32'(rq[k]));
      chk(32'(rdata.stamp - s0), 32'(24'(tq[k] - tq[0])));
      rd = 1'h1;
      repeat (3) @(negedge sys_clk_in);
      rd = 1'h0;
      settle();
    end
    chk(32'(rvalid), 32'h0);
    fscram = 1'h0;
    op_reset(1'h0);
    chk(32'(recording), 32'h0);
    stest = 1'h1;
    settle();
    chk(32'(recording), 32'h1);
    stest = 1'h0;
    wrap_up();
  end
endmodule
